// file: core/module_bus_bridge.sv
// core side control of the bridge to host-controlled modules, apb register slave
`timescale 1ns/100ps
// What this block does
// - select bit 0 lets bridge transfers reach configuration registers.
// - select bit 1 lets bridge transfers reach the clock module.
// - offset bit 1 picks clock chip-select pair 60/61 or 62/63.
// - select bit 8 lets bridge transfers reach the wake-up controller.
// - control bit 0 gates every bridge transfer; resets disabled.
// - writing 1 to read-go sets it and starts a read; 0 does nothing.
// - a read goes to the selected module at the indirect offset.
// - read-go clears when the read ends, data already in the data register.
// - write-pending is read-only, set by a data write, cleared on completion.
// - writing 1 to the clock reset bit sends one reset pulse; 0 ignored.
// - the clock reset bit clears itself when the pulse ends.
// - the offset register holds an 8-bit offset in bits 7-0.
// - a data register write launches the module bus write itself.
module module_bus_bridge (
    // clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // apb slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [bridge_pkg::APB_AW-1:0]   paddr,
    input  wire logic [bridge_pkg::APB_DW-1:0]   pwdata,
    output logic      [bridge_pkg::APB_DW-1:0]   prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // internal module bus
    output logic                                 mb_req,
    output logic                                 mb_write,
    output logic      [bridge_pkg::TGT_W-1:0]    mb_target,
    output logic      [bridge_pkg::BYTE_W-1:0]   mb_offset,
    output logic      [bridge_pkg::BYTE_W-1:0]   mb_wdata,
    output logic                                 mb_rtc_pair,
    input  wire logic                            mb_done,
    input  wire logic [bridge_pkg::BYTE_W-1:0]   mb_rdata,
    // clock module reset
    output logic                                 rtc_reset_out
);
    import bridge_pkg::*;

    typedef struct packed {
        logic                cfg_en;
        logic                rtc_en;
        logic                wake_en;
        logic                bridge_en;
        logic                read_go;
        logic                write_pending;
        logic                rtc_mr;
        logic [BYTE_W-1:0]   offset;
        logic [BYTE_W-1:0]   data;
        logic                start_rd;
        logic                start_wr;
        logic                rst_go;
        logic                blk_rd;
        logic                blk_wr;
        logic [APB_DW-1:0]   prdata;
        logic                pready;
        logic                pslverr;
    } bridge_state_type;

    bridge_state_type s_reg;
    bridge_state_type s_next;

    logic                seq_done;
    logic                seq_done_write;
    logic [BYTE_W-1:0]   seq_rdata;
    logic                rst_done;

    // address decode, used only by the access check; the read mux decodes the address itself
    function automatic logic addr_hit(input logic [APB_AW-1:0] a);
        addr_hit = (a == reg_addr(IDX_OFFSET)) || (a == reg_addr(IDX_DATA)) ||
                   (a == reg_addr(IDX_SELECT)) || (a == reg_addr(IDX_CONTROL));
    endfunction

    // read mux; reserved bits always return zero
    function automatic logic [APB_DW-1:0] read_mux(input logic [APB_AW-1:0] a,
                                                    input bridge_state_type st);
        read_mux = '0;
        if (a == reg_addr(IDX_OFFSET)) begin
            read_mux = {24'h00_0000, st.offset};
        end else if (a == reg_addr(IDX_DATA)) begin
            read_mux = {24'h00_0000, st.data};
        end else if (a == reg_addr(IDX_SELECT)) begin
            read_mux = {23'h00_0000, st.wake_en, 6'h00, st.rtc_en, st.cfg_en};
        end else if (a == reg_addr(IDX_CONTROL)) begin
            read_mux = {28'h000_0000, st.rtc_mr, st.write_pending, st.read_go,
                        st.bridge_en};
        end
    endfunction

    logic apb_setup;
    logic apb_wr;
    logic any_sel;
    logic allowed;
    logic allowed_ctl;

    // apb access completes on the edge after pready rises
    assign apb_setup   = psel & ~penable;
    assign apb_wr      = psel & penable & s_reg.pready & pwrite;
    assign any_sel     = s_reg.cfg_en | s_reg.rtc_en | s_reg.wake_en;
    assign allowed     = s_reg.bridge_en & any_sel;
    assign allowed_ctl = pwdata[CTL_EN_BIT] & any_sel;

    // hardware clears first, software sets after, so a set in the same cycle wins
    always_comb begin
        s_next          = s_reg;
        s_next.start_rd = 1'b0;
        s_next.start_wr = 1'b0;
        s_next.rst_go   = 1'b0;
        s_next.blk_rd   = 1'b0;
        s_next.blk_wr   = 1'b0;
        s_next.pready   = 1'b0;
        s_next.pslverr  = 1'b0;
        if (apb_setup) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = ~addr_hit(paddr);
            s_next.prdata  = read_mux(paddr, s_reg);
        end
        if (seq_done && !seq_done_write) begin
            s_next.data    = seq_rdata;
            s_next.read_go = 1'b0;
        end
        if (seq_done && seq_done_write) begin
            s_next.write_pending = 1'b0;
        end
        // a blocked request finishes at once without touching the module bus
        if (s_reg.blk_rd) begin
            s_next.read_go = 1'b0;
        end
        if (s_reg.blk_wr) begin
            s_next.write_pending = 1'b0;
        end
        if (rst_done) begin
            s_next.rtc_mr = 1'b0;
        end
        if (apb_wr) begin
            if (paddr == reg_addr(IDX_OFFSET)) begin
                s_next.offset = pwdata[BYTE_W-1:0];
            end else if (paddr == reg_addr(IDX_DATA)) begin
                s_next.data          = pwdata[BYTE_W-1:0];
                s_next.write_pending = 1'b1;
                s_next.start_wr      = allowed;
                s_next.blk_wr        = ~allowed;
            end else if (paddr == reg_addr(IDX_SELECT)) begin
                s_next.cfg_en  = pwdata[SEL_CFG_BIT];
                s_next.rtc_en  = pwdata[SEL_RTC_BIT];
                s_next.wake_en = pwdata[SEL_WAKE_BIT];
            end else if (paddr == reg_addr(IDX_CONTROL)) begin
                s_next.bridge_en = pwdata[CTL_EN_BIT];
                if (pwdata[CTL_RDGO_BIT]) begin
                    s_next.read_go  = 1'b1;
                    s_next.start_rd = allowed_ctl;
                    s_next.blk_rd   = ~allowed_ctl;
                end
                if (pwdata[CTL_RTCRST_BIT]) begin
                    s_next.rtc_mr = 1'b1;
                    s_next.rst_go = 1'b1;
                end
            end
        end
    end

    // all implemented bits clear on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // the sequencer holds the target and offset of the transfer it runs
    module_bus_seq u_seq (
        .pclk        (pclk),
        .presetn     (presetn),
        .start_rd    (s_reg.start_rd),
        .start_wr    (s_reg.start_wr),
        .target      ({s_reg.wake_en, s_reg.rtc_en, s_reg.cfg_en}),
        .offset      (s_reg.offset),
        .wdata       (s_reg.data),
        .done        (seq_done),
        .done_write  (seq_done_write),
        .rdata       (seq_rdata),
        .mb_req      (mb_req),
        .mb_write    (mb_write),
        .mb_target   (mb_target),
        .mb_offset   (mb_offset),
        .mb_wdata    (mb_wdata),
        .mb_rtc_pair (mb_rtc_pair),
        .mb_done     (mb_done),
        .mb_rdata    (mb_rdata)
    );

    // reset pulse for the clock module
    rtc_reset_pulser u_pulser (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (s_reg.rst_go),
        .pulse   (rtc_reset_out),
        .done    (rst_done)
    );

    assign prdata  = s_reg.prdata;
    assign pready  = s_reg.pready;
    assign pslverr = s_reg.pslverr;

    // checks
    logic ctl_wr;
    logic data_wr;
    assign ctl_wr  = apb_wr && (paddr == reg_addr(IDX_CONTROL));
    assign data_wr = apb_wr && (paddr == reg_addr(IDX_DATA));

    // a transfer needs its select bit and the bridge enable as the sequencer takes it
    property p_cfg_gate;
        @(posedge pclk) disable iff (!presetn)
        $rose(mb_req) && mb_target[TGT_CFG] |-> $past(s_reg.cfg_en && s_reg.bridge_en);
    endproperty
    a_cfg_gate: assert property (p_cfg_gate) else $error("cfg transfer without enable");

    property p_rtc_gate;
        @(posedge pclk) disable iff (!presetn)
        $rose(mb_req) && mb_target[TGT_RTC] |-> $past(s_reg.rtc_en && s_reg.bridge_en);
    endproperty
    a_rtc_gate: assert property (p_rtc_gate) else $error("rtc transfer without enable");

    // pair choice only matters for the clock module; other targets see 0
    property p_rtc_pair;
        @(posedge pclk) disable iff (!presetn)
        mb_req && mb_target[TGT_RTC] |-> mb_rtc_pair == mb_offset[RTC_PAIR_BIT];
    endproperty
    a_rtc_pair: assert property (p_rtc_pair) else $error("wrong rtc pair");

    property p_wake_gate;
        @(posedge pclk) disable iff (!presetn)
        $rose(mb_req) && mb_target[TGT_WAKE] |-> $past(s_reg.wake_en && s_reg.bridge_en);
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake transfer without enable");

    property p_bridge_off;
        @(posedge pclk) disable iff (!presetn)
        !s_reg.bridge_en && !mb_req ##1 !s_reg.bridge_en |-> !mb_req;
    endproperty
    a_bridge_off: assert property (p_bridge_off) else $error("transfer while bridge off");

    property p_read_go_zero;
        @(posedge pclk) disable iff (!presetn)
        ctl_wr && !pwdata[CTL_RDGO_BIT] && !s_reg.read_go |=> !s_reg.read_go ##1 !$rose(mb_req);
    endproperty
    a_read_go_zero: assert property (p_read_go_zero) else $error("zero write started read");

    property p_read_offset;
        @(posedge pclk) disable iff (!presetn)
        $rose(mb_req) && !mb_write |-> mb_offset == $past(s_reg.offset);
    endproperty
    a_read_offset: assert property (p_read_offset) else $error("read at wrong offset");

    property p_read_data;
        @(posedge pclk) disable iff (!presetn)
        mb_req && !mb_write && mb_done ##1 seq_done |=>
            !s_reg.read_go && s_reg.data == $past(mb_rdata, 2);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not ready at clear");

    property p_pending_set;
        @(posedge pclk) disable iff (!presetn)
        data_wr |=> s_reg.write_pending;
    endproperty
    a_pending_set: assert property (p_pending_set) else $error("write pending not set");

    property p_write_launch;
        @(posedge pclk) disable iff (!presetn)
        data_wr && allowed && !mb_req |-> ##2 mb_req && mb_write;
    endproperty
    a_write_launch: assert property (p_write_launch) else $error("data write not launched");

    property p_rst_pulse;
        @(posedge pclk) disable iff (!presetn)
        $rose(rtc_reset_out) |-> rtc_reset_out [*5] ##1 !rtc_reset_out;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("rtc reset pulse length");

    property p_rst_clear;
        @(posedge pclk) disable iff (!presetn)
        $fell(rtc_reset_out) |-> ##1 !s_reg.rtc_mr || $past(ctl_wr);
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("rtc reset bit not cleared");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        pready && !pslverr |-> prdata[APB_DW-1:9] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    // launch, completion and read-only behaviour of the busy bits
    property p_read_launch;
        @(posedge pclk) disable iff (!presetn)
        ctl_wr && pwdata[CTL_RDGO_BIT] && allowed_ctl && !mb_req |-> ##2 mb_req && !mb_write;
    endproperty
    a_read_launch: assert property (p_read_launch) else $error("read not launched");

    property p_target_copy;
        @(posedge pclk) disable iff (!presetn)
        $rose(mb_req) |-> mb_target == $past({s_reg.wake_en, s_reg.rtc_en, s_reg.cfg_en});
    endproperty
    a_target_copy: assert property (p_target_copy) else $error("wrong target");

    property p_pending_clear;
        @(posedge pclk) disable iff (!presetn)
        seq_done && seq_done_write && !data_wr |=> !s_reg.write_pending;
    endproperty
    a_pending_clear: assert property (p_pending_clear) else $error("pending stuck");

    property p_pending_ro;
        @(posedge pclk) disable iff (!presetn)
        ctl_wr && !s_reg.write_pending |=> !s_reg.write_pending;
    endproperty
    a_pending_ro: assert property (p_pending_ro) else $error("pending set by control");

    property p_blocked_write;
        @(posedge pclk) disable iff (!presetn)
        s_reg.blk_wr |=> !s_reg.write_pending;
    endproperty
    a_blocked_write: assert property (p_blocked_write) else $error("blocked write stuck");

    property p_rst_zero;
        @(posedge pclk) disable iff (!presetn)
        ctl_wr && !pwdata[CTL_RTCRST_BIT] && !s_reg.rtc_mr |=> !s_reg.rtc_mr ##1 !rtc_reset_out;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("zero write started reset");

    // main scenarios: read, write, blocked request, clock reset, upper pair
    c_pair: cover property (@(posedge pclk) disable iff (!presetn) $rose(mb_req) && mb_rtc_pair);
    c_read: cover property (@(posedge pclk) disable iff (!presetn) seq_done && !seq_done_write);
    c_write: cover property (@(posedge pclk) disable iff (!presetn) seq_done && seq_done_write);
    c_blocked: cover property (@(posedge pclk) disable iff (!presetn) s_reg.blk_rd);
    c_rst: cover property (@(posedge pclk) disable iff (!presetn) rst_done);

endmodule

// file: core/bridge_pkg.sv
// constants, register map and field layout of the core to module bus bridge
package bridge_pkg;

    // register indices; byte address on the register bus is four times the index
    localparam logic [15:0] IDX_OFFSET  = 16'hfce0;
    localparam logic [15:0] IDX_DATA    = 16'hfce2;
    localparam logic [15:0] IDX_SELECT  = 16'hfce8;
    localparam logic [15:0] IDX_CONTROL = 16'hfcea;

    // bus widths
    localparam int unsigned APB_AW = 32;
    localparam int unsigned APB_DW = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned TGT_W  = 3;

    // module select register fields
    localparam int unsigned SEL_CFG_BIT  = 0;
    localparam int unsigned SEL_RTC_BIT  = 1;
    localparam int unsigned SEL_WAKE_BIT = 8;

    // bridge control register fields
    localparam int unsigned CTL_EN_BIT     = 0;
    localparam int unsigned CTL_RDGO_BIT   = 1;
    localparam int unsigned CTL_WRPEND_BIT = 2;
    localparam int unsigned CTL_RTCRST_BIT = 3;

    // one-hot target positions on the module bus
    localparam int unsigned TGT_CFG  = 0;
    localparam int unsigned TGT_RTC  = 1;
    localparam int unsigned TGT_WAKE = 2;

    // offset bit that picks the clock module chip-select pair
    localparam int unsigned RTC_PAIR_BIT = 1;

    // reset values
    localparam logic [15:0] SELECT_RST  = 16'h0000;
    localparam logic [7:0]  CONTROL_RST = 8'h00;
    localparam logic [7:0]  OFFSET_RST  = 8'h00;
    localparam logic [7:0]  DATA_RST    = 8'h00;

    // clock module reset pulse timing
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned RTC_RST_NS     = 100;
    localparam int unsigned RTC_RST_CYCLES = (RTC_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W      = 4;

    // byte address of a register index
    function automatic logic [31:0] reg_addr(input logic [15:0] idx);
        reg_addr = {14'h0000, idx, 2'b00};
    endfunction

endpackage

// file: core/rtc_reset_pulser.sv
// fixed-length reset pulse generator for the clock module
`timescale 1ns/100ps
module rtc_reset_pulser (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // request and status
    input  wire logic start,
    output logic      pulse,
    output logic      done
);
    import bridge_pkg::*;

    typedef struct packed {
        logic                 pulse;
        logic                 done;
        logic [RST_CNT_W-1:0] cnt;
    } pulser_state_type;

    pulser_state_type s_reg;
    pulser_state_type s_next;

    // a start while the pulse runs is dropped; the pulse is never stretched
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (s_reg.pulse) begin
            if (s_reg.cnt == RST_CNT_W'(RTC_RST_CYCLES - 1)) begin
                s_next.pulse = 1'b0;
                s_next.done  = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end else if (start) begin
            s_next.pulse = 1'b1;
            s_next.cnt   = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pulse = s_reg.pulse;
    assign done  = s_reg.done;

endmodule

// file: core/module_bus_seq.sv
// single-transfer sequencer for the internal module bus
`timescale 1ns/100ps
module module_bus_seq (
    // clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // launch side
    input  wire logic                            start_rd,
    input  wire logic                            start_wr,
    input  wire logic [bridge_pkg::TGT_W-1:0]    target,
    input  wire logic [bridge_pkg::BYTE_W-1:0]   offset,
    input  wire logic [bridge_pkg::BYTE_W-1:0]   wdata,
    output logic                                 done,
    output logic                                 done_write,
    output logic [bridge_pkg::BYTE_W-1:0]        rdata,
    // internal module bus
    output logic                                 mb_req,
    output logic                                 mb_write,
    output logic [bridge_pkg::TGT_W-1:0]         mb_target,
    output logic [bridge_pkg::BYTE_W-1:0]        mb_offset,
    output logic [bridge_pkg::BYTE_W-1:0]        mb_wdata,
    output logic                                 mb_rtc_pair,
    input  wire logic                            mb_done,
    input  wire logic [bridge_pkg::BYTE_W-1:0]   mb_rdata
);
    import bridge_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } seq_st_type;

    typedef struct packed {
        seq_st_type          st;
        logic                req;
        logic                write;
        logic [TGT_W-1:0]    target;
        logic [BYTE_W-1:0]   offset;
        logic [BYTE_W-1:0]   wdata;
        logic                pair;
        logic                done;
        logic                done_write;
        logic [BYTE_W-1:0]   rdata;
    } seq_state_type;

    seq_state_type s_reg;
    seq_state_type s_next;

    // request fields are frozen for the whole transfer
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            ST_IDLE: begin
                if (start_rd || start_wr) begin
                    s_next.st     = ST_BUSY;
                    s_next.req    = 1'b1;
                    s_next.write  = start_wr;
                    s_next.target = target;
                    s_next.offset = offset;
                    s_next.wdata  = wdata;
                    s_next.pair   = target[TGT_RTC] & offset[RTC_PAIR_BIT];
                end
            end
            ST_BUSY: begin
                if (mb_done) begin
                    s_next.st         = ST_IDLE;
                    s_next.req        = 1'b0;
                    s_next.done       = 1'b1;
                    s_next.done_write = s_reg.write;
                    if (!s_reg.write) begin
                        s_next.rdata = mb_rdata;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg    <= '0;
            s_reg.st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign mb_req      = s_reg.req;
    assign mb_write    = s_reg.write;
    assign mb_target   = s_reg.target;
    assign mb_offset   = s_reg.offset;
    assign mb_wdata    = s_reg.wdata;
    assign mb_rtc_pair = s_reg.pair;
    assign done        = s_reg.done;
    assign done_write  = s_reg.done_write;
    assign rdata       = s_reg.rdata;

endmodule

// file: tb/module_bus_model.sv
// behavioural responder that stands on the far side of the internal module bus
`timescale 1ns/100ps
module module_bus_model
    import bridge_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // internal module bus
    input  wire logic              mb_req,
    input  wire logic              mb_write,
    input  wire logic [TGT_W-1:0]  mb_target,
    input  wire logic [BYTE_W-1:0] mb_offset,
    input  wire logic [BYTE_W-1:0] mb_wdata,
    input  wire logic              mb_rtc_pair,
    output logic                   mb_done,
    output logic      [BYTE_W-1:0] mb_rdata,
    // bench view
    input  wire logic [3:0]        delay,
    output logic      [20:0]       seen,
    output logic      [7:0]        req_count
);
    logic [3:0] wait_cnt;

    // answer after delay cycles; read data churns whenever it is not valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt  <= 4'h0;
            mb_done   <= 1'b0;
            mb_rdata  <= 8'h5a;
            seen      <= '0;
            req_count <= 8'h00;
        end else begin
            mb_done  <= 1'b0;
            mb_rdata <= ~mb_rdata;
            if (mb_req && !mb_done) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt == delay) begin
                    wait_cnt  <= 4'h0;
                    mb_done   <= 1'b1;
                    mb_rdata  <= mb_offset ^ {5'h00, mb_target} ^ 8'ha0;
                    seen      <= {mb_write, mb_rtc_pair, mb_target, mb_offset, mb_wdata};
                    req_count <= req_count + 8'h01;
                end
            end
        end
    end
endmodule

// file: tb/test_module_bus_bridge.sv
// self-checking bench for the core to module bus bridge
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_module_bus_bridge;
    import bridge_pkg::*;
    typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_type;
    localparam logic [31:0] A_OFF = {14'h0000, IDX_OFFSET, 2'b00};
    localparam logic [31:0] A_DAT = {14'h0000, IDX_DATA, 2'b00};
    localparam logic [31:0] A_SEL = {14'h0000, IDX_SELECT, 2'b00};
    localparam logic [31:0] A_CTL = {14'h0000, IDX_CONTROL, 2'b00};
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [31:0]       paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [3:0]        delay = 4'h0;
    logic [31:0]       prdata, rdat;
    logic              pready, pslverr, rerr, mb_req, mb_write, mb_rtc_pair, mb_done;
    logic              rtc_reset_out;
    logic [2:0]        mb_target;
    logic [7:0]        mb_offset, mb_wdata, mb_rdata, req_count;
    logic [20:0]       seen;
    int                bad_count = 0;
    int                check_count = 0;
    int                hi;
    row_type           rows [4] = '{
        '{A_OFF, 32'hffff_ffa5, 32'h0000_00a5, 1'b0},
        '{A_SEL, 32'hffff_ffff, 32'h0000_0103, 1'b0},
        '{A_CTL, 32'hffff_fff5, 32'h0000_0001, 1'b0},
        '{A_CTL + 32'h0000_0010, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
    logic [31:0]       regs [4] = '{A_OFF, A_DAT, A_SEL, A_CTL};
    logic [31:0]       sels [4] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0002, 32'h0000_0100};
    logic [7:0]        offs [4] = '{8'h13, 8'h60, 8'h62, 8'h47};
    logic [2:0]        tgts [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
    logic              pairs [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    module_bus_bridge DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mb_req, .mb_write, .mb_target, .mb_offset,
        .mb_wdata, .mb_rtc_pair, .mb_done, .mb_rdata, .rtc_reset_out);
    module_bus_model far_end (.pclk, .presetn, .mb_req, .mb_write, .mb_target, .mb_offset,
        .mb_wdata, .mb_rtc_pair, .mb_done, .mb_rdata, .delay, .seen, .req_count);

    // free-running 50 MHz clock
    always #10 pclk = ~pclk;

    // final report; every path of the run ends here
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            bad_count++;
            give_verdict();
        end
    endtask

    // firmware waits for busy bits to drop before the next transfer
    task automatic poll(input logic [31:0] m);
        int n = 0;
        do begin
            apb(1'b0, A_CTL, '0);
            n++;
        end while ((rdat & m) !== '0 && n < 40);
        if (n == 40) begin
            bad_count++;
            give_verdict();
        end
    endtask

    // counts clock cycles with the clock module reset high
    task automatic count_pulse();
        hi = 0;
        repeat (30) begin
            @(posedge pclk);
            hi += int'(rtc_reset_out === 1'b1);
        end
    endtask

    // table first, then reset, blocking, transfers per target and clock reset
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, '0);
            `CHK(rdat, rows[i].r)
            `CHK(rerr, rows[i].e)
        end
        $display("register table done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) begin
            apb(1'b0, regs[i], '0);
            `CHK(rdat, 32'h0000_0000)
        end
        $display("reset values done");
        apb(1'b1, A_CTL, 32'h0000_0003);
        apb(1'b1, A_SEL, 32'h0000_0001);
        apb(1'b1, A_CTL, 32'h0000_0002);
        apb(1'b1, A_DAT, 32'h0000_0077);
        poll(32'h0000_0006);
        `CHK(req_count, 8'h00)
        $display("blocked transfers done");
        for (int i = 0; i < 4; i++) begin
            delay <= 4'(i * 3);
            apb(1'b1, A_SEL, sels[i]);
            apb(1'b1, A_OFF, {24'h00_0000, offs[i]});
            apb(1'b1, A_CTL, 32'h0000_0003);
            poll(32'h0000_0002);
            `CHK(seen[20:8], {1'b0, pairs[i], tgts[i], offs[i]})
            apb(1'b0, A_DAT, '0);
            `CHK(rdat[7:0], offs[i] ^ {5'h00, tgts[i]} ^ 8'ha0)
            apb(1'b1, A_DAT, 32'h0000_003c + i);
            apb(1'b0, A_CTL, '0);
            `CHK(rdat[2], 1'b1)
            poll(32'h0000_0004);
            `CHK(seen, {1'b1, pairs[i], tgts[i], offs[i], 8'(8'h3c + i)})
        end
        $display("transfers per target done");
        apb(1'b1, A_CTL, 32'h0000_0009);
        count_pulse();
        `CHK(hi, int'(RTC_RST_CYCLES))
        apb(1'b0, A_CTL, '0);
        `CHK(rdat, 32'h0000_0001)
        apb(1'b1, A_CTL, 32'h0000_0001);
        count_pulse();
        `CHK(hi, 0)
        `CHK(req_count, 8'h08)
        $display("clock module reset done");
        give_verdict();
    end
endmodule
